// ### core/acs_conv_ctrl.v
// acs_conv_ctrl.v: calibration register access and conversion start control
// assumes a parallel host bus with one-cycle rd/wr strobes on i_clk_sys and
// an active-low start pin and a master clock pin, both asynchronous
`timescale 1ns/1ps
`include "acs_map.vh"

module acs_conv_ctrl
(
  input wire i_clk_sys,
  input wire i_srst,
  input wire i_conversion_start_pin_n,
  input wire i_master_clock_input,
  input wire i_byte_mode,
  input wire i_high_byte_enable,
  input wire i_wr,
  input wire i_rd,
  input wire i_ctl_sel,
  input wire [15:0] i_wdata,
  input wire [11:0] i_result,
  input wire i_cal_upd,
  input wire [3:0] i_cal_upd_idx,
  input wire [13:0] i_cal_upd_data,
  output reg [15:0] o_rdata,
  output reg o_busy,
  output reg o_hold,
  output reg o_calibrating,
  output reg o_convert_bit,
  output wire [1:0] o_cal_select,
  output reg [3:0] o_cal_ptr
);

  localparam ST_IDLE = 4'h1;
  localparam ST_WAIT = 4'h2;
  localparam ST_CONV = 4'h4;
  localparam ST_CAL = 4'h8;

  reg [15:0] cal_mem [0:`ACS_NUM_CAL-1];
  reg [1:0] cal_sel;
  reg [1:0] rd_sel;
  reg [3:0] state;
  reg [5:0] half_cnt;
  reg [5:0] half_target;
  reg cst_s1;
  reg cst_s2;
  reg cst_d;
  reg mck_s1;
  reg mck_s2;
  reg mck_d;
  reg [3:0] since_start;
  reg powered_up;
  reg sw_start_pend;
  reg [3:0] next_ptr;
  integer i;

  wire wr_ctl = i_wr & i_ctl_sel;
  wire wr_cal = i_wr & ~i_ctl_sel;
  wire rd_cal = i_rd & ~i_ctl_sel & (rd_sel == `ACS_RDSEL_CAL);
  wire cal_access = wr_cal | rd_cal;
  // full access: word strobe, or high byte in byte mode
  wire full_access = cal_access & (~i_byte_mode | i_high_byte_enable);
  wire pin_rise = cst_s2 & ~cst_d;
  wire mck_fall = ~mck_s2 & mck_d;
  wire mck_rise = mck_s2 & ~mck_d;
  wire conv_done = (half_cnt == half_target);
  wire sw_start = wr_ctl & i_wdata[`ACS_CTL_CONV_BIT];
  wire start_evt = pin_rise | sw_start;
  wire [1:0] sel_now = wr_ctl & i_wdata[`ACS_CTL_CALSEL_WR] ?
    {i_wdata[`ACS_CTL_CALSEL_HI], i_wdata[`ACS_CTL_CALSEL_LO]} : cal_sel;

  assign o_cal_select = cal_sel;

  // first register of a sequence
  function [3:0] seq_first;
    input [1:0] sel;
    begin
      seq_first = (sel == `ACS_CAL_OFS) ? `ACS_IDX_OFS : `ACS_IDX_GAIN;
    end
  endfunction

  // last register of a sequence
  function [3:0] seq_last;
    input [1:0] sel;
    begin
      case (sel)
        `ACS_CAL_FULL: seq_last = `ACS_IDX_LAST;
        `ACS_CAL_GAIN_OFS: seq_last = `ACS_IDX_OFS;
        `ACS_CAL_OFS: seq_last = `ACS_IDX_OFS;
        default: seq_last = `ACS_IDX_GAIN;
      endcase
    end
  endfunction

  // read word of a calibration register, top two bits always zero
  function [15:0] cal_rd_word;
    input [15:0] word;
    input byte_mode;
    input high_byte;
    begin
      if (byte_mode && !high_byte)
        cal_rd_word = {8'h00, word[7:0]};
      else if (byte_mode)
        cal_rd_word = {8'h00, 2'h0, word[13:8]};
      else
        cal_rd_word = word & `ACS_CAL_MASK;
    end
  endfunction

  // status word: busy, select and calibration flags
  function [15:0] status_word;
    input busy;
    input [1:0] sel;
    input cal;
    begin
      status_word = {8'h00, 2'h3, 1'b0, busy, 1'b0, sel, cal};
    end
  endfunction

  // cycles since the start event, gives the setup ahead of the master fall
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
      since_start <= 4'h0;
    else if (state == ST_IDLE && start_evt)
      since_start <= 4'h0;
    else if (since_start != 4'hF)
      since_start <= since_start + 4'h1;
  end

  // pin synchronisers
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      cst_s1 <= 1'b1;
      cst_s2 <= 1'b1;
      cst_d <= 1'b1;
      mck_s1 <= 1'b0;
      mck_s2 <= 1'b0;
      mck_d <= 1'b0;
    end
    else
    begin
      cst_s1 <= i_conversion_start_pin_n;
      cst_s2 <= cst_s1;
      cst_d <= cst_s2;
      mck_s1 <= i_master_clock_input;
      mck_s2 <= mck_s1;
      mck_d <= mck_s2;
    end
  end

  // pointer next value
  always @*
  begin
    next_ptr = o_cal_ptr;
    if (wr_ctl)
      next_ptr = seq_first(sel_now);
    else if (full_access)
    begin
      if (o_cal_ptr == seq_last(cal_sel))
        next_ptr = seq_first(cal_sel);
      else if (o_cal_ptr == `ACS_IDX_GAIN && cal_sel == `ACS_CAL_FULL)
        next_ptr = `ACS_IDX_OFS;
      else
        next_ptr = o_cal_ptr + 4'h1;
    end
  end

  // control fields, pointer and calibration registers
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      cal_sel <= `ACS_CAL_FULL;
      rd_sel <= `ACS_RDSEL_RESULT;
      o_cal_ptr <= `ACS_IDX_GAIN;
      cal_mem[`ACS_IDX_GAIN] <= `ACS_GAIN_RESET;
      cal_mem[`ACS_IDX_OFS] <= `ACS_OFS_RESET;
      for (i = `ACS_IDX_DAC0; i < `ACS_NUM_CAL; i = i + 1)
        cal_mem[i] <= `ACS_DAC_RESET;
    end
    else
    begin
      if (wr_ctl)
      begin
        rd_sel <= {i_wdata[`ACS_CTL_RDSEL_HI], i_wdata[`ACS_CTL_RDSEL_LO]};
        cal_sel <= sel_now;
      end
      o_cal_ptr <= next_ptr;
      if (o_calibrating && i_cal_upd && i_cal_upd_idx <= `ACS_IDX_LAST)
        cal_mem[i_cal_upd_idx] <= {2'h0, i_cal_upd_data};
      else if (wr_cal && !o_calibrating)
      begin
        // byte mode: low or high byte lane of the addressed register
        if (i_byte_mode && !i_high_byte_enable)
          cal_mem[o_cal_ptr][7:0] <= i_wdata[7:0];
        else if (i_byte_mode)
          cal_mem[o_cal_ptr][15:8] <= {2'h0, i_wdata[5:0]};
        else
          cal_mem[o_cal_ptr] <= i_wdata & `ACS_CAL_MASK;
      end
    end
  end

  // read data
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
      o_rdata <= 16'h0000;
    else if (i_rd)
    begin
      if (rd_cal)
        o_rdata <= cal_rd_word(cal_mem[o_cal_ptr], i_byte_mode, i_high_byte_enable);
      else if (rd_sel == `ACS_RDSEL_STATUS)
        o_rdata <= status_word(o_busy, cal_sel, o_calibrating);
      else
        o_rdata <= {4'h0, i_result};
    end
  end

  // conversion sequencer
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      state <= ST_IDLE;
      o_busy <= 1'b0;
      o_hold <= 1'b0;
      o_calibrating <= 1'b0;
      o_convert_bit <= 1'b0;
      powered_up <= 1'b0;
      sw_start_pend <= 1'b0;
      half_cnt <= 6'h00;
      half_target <= 6'h00;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (sw_start)
            o_convert_bit <= 1'b1;
          if (start_evt)
          begin
            o_hold <= 1'b1;
            o_busy <= 1'b1;
            sw_start_pend <= sw_start;
            state <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (mck_fall)
          begin
            half_cnt <= 6'h00;
            // start edge too close to this master edge costs one period
            if (since_start < `ACS_SETUP_CYC)
              half_target <= `ACS_CONV_HALVES_SLOW;
            else
              half_target <= `ACS_CONV_HALVES_FAST;
            if (!powered_up)
            begin
              o_calibrating <= 1'b1;
              half_target <= `ACS_SELFCAL_HALVES;
              state <= ST_CAL;
            end
            else
              state <= ST_CONV;
          end
        end
        ST_CONV, ST_CAL:
        begin
          // both master edges count, one half period each
          if (mck_fall || mck_rise)
            half_cnt <= half_cnt + 6'h01;
          if (conv_done)
          begin
            o_busy <= 1'b0;
            o_hold <= 1'b0;
            o_convert_bit <= 1'b0;
            o_calibrating <= 1'b0;
            powered_up <= 1'b1;
            sw_start_pend <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule // acs_conv_ctrl

// ### include/acs_map.vh
// acs_map.vh: offsets, field positions, reset values and timing counts
// assumes inclusion by the single core file of the converter control block
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// control word fields (bus data bits)
`define ACS_CTL_CONV_BIT 0
`define ACS_CTL_CALSEL_LO 1
`define ACS_CTL_CALSEL_HI 2
`define ACS_CTL_RDSEL_LO 3
`define ACS_CTL_RDSEL_HI 4
`define ACS_CTL_CALSEL_WR 5

// read select codes
`define ACS_RDSEL_RESULT 2'h0
`define ACS_RDSEL_CAL 2'h2
`define ACS_RDSEL_STATUS 2'h3

// calibration select codes
`define ACS_CAL_FULL 2'h0
`define ACS_CAL_GAIN_OFS 2'h1
`define ACS_CAL_OFS 2'h2
`define ACS_CAL_GAIN 2'h3

// register indices inside the calibration array
`define ACS_IDX_GAIN 4'h0
`define ACS_IDX_OFS 4'h1
`define ACS_IDX_DAC0 4'h2
`define ACS_IDX_LAST 4'h9
`define ACS_NUM_CAL 10

// reset contents
`define ACS_OFS_RESET 16'h2000
`define ACS_GAIN_RESET 16'h2000
`define ACS_DAC_RESET 16'h2000
`define ACS_CAL_MASK 16'h3FFF

// timing: master clock half periods in system cycles
`define ACS_CLK_PERIOD_NS 10
`define ACS_MCLK_HALF_NS 120
`define ACS_MCLK_HALF_CYC (`ACS_MCLK_HALF_NS / `ACS_CLK_PERIOD_NS)
// conversion lengths in master clock half periods
`define ACS_CONV_HALVES_FAST 6'h21
`define ACS_CONV_HALVES_SLOW 6'h23
`define ACS_SETUP_NS 10
`define ACS_SETUP_CYC ((`ACS_SETUP_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
// self calibration length in master clock half periods
`define ACS_SELFCAL_HALVES 6'h28

`endif

// ### testbench/acs_host.sv
// acs_host.sv: host processor model on the parallel bus
// assumes xfer is called at a falling clock edge
`timescale 1ns/1ps
module acs_host
(
  input wire i_clk,
  input wire [15:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic o_ctl_sel,
  output logic o_hbe,
  output logic [15:0] o_wdata
);
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_ctl_sel = 1'b0;
    o_hbe = 1'b0;
    o_wdata = 16'h0000;
  end
  // one strobe per call; released data shows its inverse
  task xfer(input logic rd, ctl, hb, input logic [15:0] d, output logic [15:0] q);
    @(negedge i_clk);
    o_rd = rd;
    o_wr = !rd;
    o_ctl_sel = ctl;
    o_hbe = hb;
    o_wdata = d;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = ~d;
    @(negedge i_clk);
    q = i_rdata;
  endtask
endmodule // acs_host

// ### testbench/acs_props.sv
// acs_props.sv: port checker for acs_conv_ctrl
// assumes binding to every acs_conv_ctrl instance
`timescale 1ns/1ps
module acs_props
(
  input wire i_clk_sys,
  input wire i_srst,
  input wire i_byte_mode,
  input wire i_high_byte_enable,
  input wire i_wr,
  input wire i_rd,
  input wire i_ctl_sel,
  input wire [15:0] i_wdata,
  input wire [15:0] o_rdata,
  input wire o_busy,
  input wire o_hold,
  input wire o_convert_bit,
  input wire [3:0] o_cal_ptr
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  int bcnt = 0;
  wire cw = i_wr && i_ctl_sel && i_wdata[5];
  // busy run length, caps conversion and calibration time
  always @(posedge i_clk_sys)
    bcnt <= (i_srst || !o_busy) ? 0 : bcnt + 1;
  AST_PTR_RANGE: assert property (o_cal_ptr <= 4'h9)
    else $error("ptr range");
  AST_OFS_FIRST: assert property (cw && i_wdata[2:1] == 2'h2 |=> o_cal_ptr == 4'h1)
    else $error("ofs first");
  AST_GAIN_FIRST: assert property (cw && i_wdata[2:1] != 2'h2 |=> o_cal_ptr == 4'h0)
    else $error("gain first");
  AST_BYTE_LOW: assert property ((i_wr || i_rd) && !i_ctl_sel && i_byte_mode
    && !i_high_byte_enable |=> $stable(o_cal_ptr)) else $error("low byte moved ptr");
  AST_RD_TOP: assert property (o_rdata[15:14] == 2'h0)
    else $error("top bits set");
  AST_BUSY_FALL: assert property ($fell(o_busy) |-> !o_hold && !o_convert_bit)
    else $error("busy fall");
  AST_SW_START: assert property (i_wr && i_ctl_sel && i_wdata[0] && !o_busy
    |-> ##[1:3] o_busy && o_hold) else $error("sw start");
  AST_BUSY_LEN: assert property (bcnt < 600)
    else $error("busy too long");
endmodule // acs_props
bind acs_conv_ctrl acs_props u_props (.*);

// ### testbench/tb.sv
// tb.sv: self-checking bench for acs_conv_ctrl
// assumes acs_host on the bus; start pin and master clock made here
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic pin_n = 1'b1;
  logic mclk = 1'b0;
  logic bmode = 1'b0;
  logic cupd = 1'b0;
  logic [3:0] cidx = 4'h0;
  logic [13:0] cdat = 14'h0000;
  wire wr, rd, ctl, hbe, busy, hold, calib, cbit;
  wire [15:0] wdata, rdata;
  wire [1:0] sel;
  wire [3:0] ptr;
  logic [15:0] q;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  initial forever #5 clk = ~clk;
  initial #3 forever #120 mclk = ~mclk;
  acs_host host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_ctl_sel(ctl),
    .o_hbe(hbe), .o_wdata(wdata));
  acs_conv_ctrl dut (.i_clk_sys(clk), .i_srst(srst), .i_conversion_start_pin_n(pin_n),
    .i_master_clock_input(mclk), .i_byte_mode(bmode), .i_high_byte_enable(hbe),
    .i_wr(wr), .i_rd(rd), .i_ctl_sel(ctl), .i_wdata(wdata), .i_result(12'h000),
    .i_cal_upd(cupd), .i_cal_upd_idx(cidx), .i_cal_upd_data(cdat), .o_rdata(rdata),
    .o_busy(busy), .o_hold(hold), .o_calibrating(calib), .o_convert_bit(cbit),
    .o_cal_select(sel), .o_cal_ptr(ptr));
  task finish_test;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task pin_start;
    pin_n = 1'b0;
    repeat (2) @(negedge clk);
    pin_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  // no bus traffic while busy
  task conv(output int len);
    len = 0;
    while (busy === 1'b1 && len < 1000)
    begin
      @(negedge clk);
      len++;
    end
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      finish_test();
    end
  end
  initial
  begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    check("ptr_rst", ptr, 16'h0000);
    pin_start();
    repeat (30) @(negedge clk);
    check("selfcal", {calib, busy, hold}, 16'h0007);
    cdat = 14'h1234;
    cidx = 4'h1;
    cupd = 1'b1;
    @(negedge clk);
    cupd = 1'b0;
    conv(n);
    check("idle", {calib, busy, hold}, 16'h0000);
    host.xfer(0, 1, 0, 16'h0034, q);
    host.xfer(1, 0, 0, 16'h0000, q);
    check("cal_upd", q, 16'h1234);
    pin_start();
    check("hold", {calib, busy, hold}, 16'h0003);
    conv(n);
    check("pin_len", n > 380 && n < 460, 16'h0001);
    host.xfer(0, 1, 0, 16'h0020, q);
    for (int i = 0; i < 10; i++)
    begin
      check("ptr_wr", ptr, i);
      host.xfer(0, 0, 0, 16'hC000 | 16'(i) * 16'h0123, q);
    end
    check("ptr_wrap", ptr, 16'h0000);
    host.xfer(0, 1, 0, 16'h0030, q);
    for (int i = 0; i < 10; i++)
    begin
      host.xfer(1, 0, 0, 16'h0000, q);
      check("cal_rd", q, 16'(i) * 16'h0123);
    end
    for (int s = 1; s < 4; s++)
    begin
      host.xfer(0, 1, 0, 16'h0020 | 16'(s << 1), q);
      check("sel", sel, s);
      check("ptr_first", ptr, s == 2);
      host.xfer(0, 0, 0, 16'h0100, q);
      check("ptr_next", ptr, s != 3);
    end
    host.xfer(0, 1, 0, 16'h0032, q);
    bmode = 1'b1;
    host.xfer(1, 0, 0, 16'h0000, q);
    check("rd_lo", q, 16'h0000);
    check("ptr_lo", ptr, 16'h0000);
    host.xfer(1, 0, 1, 16'h0000, q);
    check("rd_hi", q, 16'h0001);
    check("ptr_hi", ptr, 16'h0001);
    bmode = 1'b0;
    host.xfer(0, 1, 0, 16'h0020, q);
    repeat (3) host.xfer(0, 0, 0, 16'h0100, q);
    check("ptr_mid", ptr, 16'h0003);
    host.xfer(0, 1, 0, 16'h0020, q);
    check("ptr_abort", ptr, 16'h0000);
    host.xfer(0, 1, 0, 16'h0001, q);
    check("sw_start", {cbit, busy, hold}, 16'h0007);
    conv(n);
    check("sw_end", {cbit, busy, hold}, 16'h0000);
    check("sw_len", n > 380 && n < 460, 16'h0001);
    finish_test();
  end
endmodule // tb
